//--- shared/utcr_pkg.sv
package utcr_pkg;

   // Register byte addresses on the plain register port.
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_CMD     = 8'h04;
   localparam logic [7:0] OFF_STATUS  = 8'h08;
   localparam logic [7:0] OFF_WPTR    = 8'h0c;
   localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
   localparam logic [7:0] OFF_IRQ_EN  = 8'h18;
   localparam logic [7:0] OFF_RD_ADDR = 8'h1c;
   localparam logic [7:0] OFF_RD_DATA = 8'h20;

   // Control register fields.
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_NOIDLE    = 2;
   localparam int CTRL_LOWSPEED  = 3;
   localparam int CTRL_SIZE_LSB  = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_00a0;

   // Command register fields.
   localparam int CMD_RECORD = 0;
   localparam int CMD_STOP   = 1;

   // Status register fields.
   localparam int ST_ARMED     = 0;
   localparam int ST_CAPTURING = 1;
   localparam int ST_TRIGGERED = 2;
   localparam int ST_FULL      = 3;
   localparam int ST_WRAPPED   = 4;

   // Interrupt event bits.
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_W    = 2;

   // Size setting counts tenths of the buffer, from one to ten.
   localparam logic [3:0] SIZE_MIN = 4'h1;
   localparam logic [3:0] SIZE_MAX = 4'ha;

   // Sampling rates.
   localparam int CLK_HZ     = 100_000_000;
   localparam int FS_RATE_HZ = 12_000_000;
   localparam int LS_RATE_HZ = 1_500_000;
   localparam int FS_DIV     = CLK_HZ / FS_RATE_HZ;
   localparam int LS_DIV     = CLK_HZ / LS_RATE_HZ;

   // Line states as seen on D+ and D- at full speed.
   localparam logic [1:0] LINE_J  = 2'b10;
   localparam logic [1:0] LINE_K  = 2'b01;
   localparam logic [1:0] LINE_SE0 = 2'b00;

   typedef enum logic [1:0] {MODE_MANUAL, MODE_EXT_START, MODE_EXT_STOP, MODE_RSVD} utcr_mode_t;
   typedef enum {ST_IDLE, ST_WAIT_TRIG, ST_CAPTURE} utcr_state_t;

endpackage

//--- verilog/utcr_sample_tick.sv
`timescale 1ns/1ps
`default_nettype none
// Produces one pulse per bit time at the selected bus rate.
module utcr_sample_tick (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_in,
   // Control
   input  wire logic low_speed_in,
   // Tick
   output logic      tick_out
);
   import utcr_pkg::*;

   localparam logic [6:0] FS_LAST = 7'(FS_DIV - 1);
   localparam logic [6:0] LS_LAST = 7'(LS_DIV - 1);

   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       tick_r;
   logic       tick_nxt;

   // The divider restarts when it reaches or passes the limit, so a speed change takes
   // effect within one low-speed bit without a glitch tick.
   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt  = cnt_r + 7'h01;
      if (cnt_r >= (low_speed_in ? LS_LAST : FS_LAST)) begin
         cnt_nxt  = 7'h00;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r  <= 7'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_out = tick_r;

   tick_spacing_a: assert property (@(posedge clock_in) disable iff (rst_in)
      tick_r && low_speed_in && $past(low_speed_in) |=> !tick_r [*7] ##1
         (!tick_r || !$past(low_speed_in)))
      else $error("Low-speed tick came too soon.");

endmodule
`default_nettype wire

//--- verilog/utcr_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Capture memory with one write port and one registered read port.
module utcr_mem #(
   parameter int AW = 10,
   parameter int DW = 2
) (
   // Clock
   input  wire logic          clock_in,
   // Write port
   input  wire logic          wr_en_in,
   input  wire logic [AW-1:0] wr_addr_in,
   input  wire logic [DW-1:0] wr_data_in,
   // Read port
   input  wire logic [AW-1:0] rd_addr_in,
   output logic      [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem_r [0:(1<<AW)-1];
   logic [DW-1:0] rd_r;

   always_ff @(posedge clock_in) begin
      if (wr_en_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
      rd_r <= mem_r[rd_addr_in];
   end

   assign rd_data_out = rd_r;

endmodule
`default_nettype wire

//--- verilog/utcr_recorder.sv
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Manual mode: record starts capture; stops at buffer full or stop.
// - External-start: record only arms; trigger starts; full or stop ends.
// - External-stop: record starts capture; trigger or stop ends it.
// - External-stop writes circularly, keeping the latest buffer span.
// - Trigger input is active low and used only in external modes.
// - By default every sample, idle included, is stored.
// - With idle skipping, pause at idle, resume at J to K transition.
// - A triggered flag is visible to software.
// - Low speed switches sampling from 12 MHz to 1.5 MHz.
// - Low speed swaps D+ and D- in the captured data.
// - Buffer size setting limits memory to tenths; full at that limit in manual and external-start; external-stop wraps there.
// - Writing settings never starts capture; only record does.
module utcr_recorder #(
   parameter int AW = 10
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // Monitored bus and trigger
   input  wire logic        dp_in,
   input  wire logic        dm_in,
   input  wire logic        trig_n_in,
   // Interrupt
   output logic             irq_out
);
   import utcr_pkg::*;

   localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

   // Register state.
   logic [31:0]       ctrl_r;
   logic [31:0]       ctrl_nxt;
   logic [AW-1:0]     rd_addr_r;
   logic [AW-1:0]     rd_addr_nxt;
   logic [IRQ_W-1:0]  irq_st_r;
   logic [IRQ_W-1:0]  irq_st_nxt;
   logic [IRQ_W-1:0]  irq_en_r;
   logic [IRQ_W-1:0]  irq_en_nxt;
   logic [31:0]       rdata_r;
   logic [31:0]       rdata_nxt;
   logic              irq_r;
   logic              irq_nxt;

   // Capture state.
   utcr_state_t       state_r;
   utcr_state_t       state_nxt;
   logic [AW-1:0]     wptr_r;
   logic [AW-1:0]     wptr_nxt;
   logic [AW:0]       count_r;
   logic [AW:0]       count_nxt;
   logic              trig_seen_r;
   logic              trig_seen_nxt;
   logic              full_r;
   logic              full_nxt;
   logic              wrapped_r;
   logic              wrapped_nxt;
   logic              pause_r;
   logic              pause_nxt;
   logic [1:0]        line_r;
   logic [1:0]        line_nxt;
   utcr_mode_t        run_mode_r;
   utcr_mode_t        run_mode_nxt;
   logic [AW:0]       limit_r;
   logic [AW:0]       limit_nxt;

   // Trigger synchroniser.
   logic              trig_s1_r;
   logic              trig_s2_r;
   logic              trig_s3_r;

   logic              tick;
   logic [1:0]        mem_rdata;
   logic              wr_cmd;
   logic              cmd_record;
   logic              cmd_stop;
   logic              trig_fall;
   logic              ext_mode;
   logic              mem_we;
   logic [1:0]        sample;
   logic              ev_trig;
   logic              ev_done;

   // Limit in samples for a size setting of one to ten tenths.
   function automatic logic [AW:0] size_limit(input logic [3:0] tenths);
      logic [3:0]    t;
      logic [AW+4:0] prod;
      t = (tenths < SIZE_MIN) ? SIZE_MIN : ((tenths > SIZE_MAX) ? SIZE_MAX : tenths);
      prod = (AW+5)'(DEPTH) * (AW+5)'(t);
      return (AW+1)'(prod / (AW+5)'(SIZE_MAX));
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   utcr_sample_tick u_tick (
      .clock_in     (clock_in),
      .rst_in       (rst_in),
      .low_speed_in (ctrl_r[CTRL_LOWSPEED]),
      .tick_out     (tick)
   );

   utcr_mem #(.AW(AW), .DW(2)) u_mem (
      .clock_in    (clock_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (wptr_r),
      .wr_data_in  (sample),
      .rd_addr_in  (rd_addr_nxt),
      .rd_data_out (mem_rdata)
   );

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         trig_s1_r <= 1'b1;
         trig_s2_r <= 1'b1;
         trig_s3_r <= 1'b1;
      end else begin
         trig_s1_r <= trig_n_in;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end

   assign wr_cmd     = wr_in && is_addr(addr_in, OFF_CMD);
   assign cmd_record = wr_cmd && wdata_in[CMD_RECORD];
   assign cmd_stop   = wr_cmd && wdata_in[CMD_STOP];
   // Active-low trigger counts on its falling edge, only in external modes.
   assign ext_mode   = (run_mode_r == MODE_EXT_START) || (run_mode_r == MODE_EXT_STOP);
   assign trig_fall  = ext_mode && trig_s3_r && !trig_s2_r;
   // Low speed stores the line with the pair swapped, so J reads as at full speed.
   assign sample     = ctrl_r[CTRL_LOWSPEED] ? {dm_in, dp_in} : {dp_in, dm_in};
   assign mem_we     = (state_r == ST_CAPTURE) && tick && !full_r && !pause_nxt;

   // Capture sequencer.
   always_comb begin
      state_nxt     = state_r;
      wptr_nxt      = wptr_r;
      count_nxt     = count_r;
      trig_seen_nxt = trig_seen_r;
      full_nxt      = full_r;
      wrapped_nxt   = wrapped_r;
      pause_nxt     = pause_r;
      line_nxt      = line_r;
      run_mode_nxt  = run_mode_r;
      limit_nxt     = limit_r;
      ev_trig       = 1'b0;
      ev_done       = 1'b0;
      if (tick) begin
         line_nxt = sample;
         // Idle is J held between packets; SOP is the J to K step.
         if (ctrl_r[CTRL_NOIDLE]) begin
            if (line_r == LINE_J && sample == LINE_K) begin
               pause_nxt = 1'b0;
            end else if (line_r == LINE_J && sample == LINE_J) begin
               pause_nxt = 1'b1;
            end
         end else begin
            pause_nxt = 1'b0;
         end
      end
      case (state_r)
         ST_IDLE: begin
            if (cmd_record) begin
               run_mode_nxt  = utcr_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
               limit_nxt     = size_limit(ctrl_r[CTRL_SIZE_LSB +: 4]);
               wptr_nxt      = '0;
               count_nxt     = '0;
               full_nxt      = 1'b0;
               wrapped_nxt   = 1'b0;
               trig_seen_nxt = 1'b0;
               pause_nxt     = ctrl_r[CTRL_NOIDLE];
               if (utcr_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]) == MODE_EXT_START) begin
                  state_nxt = ST_WAIT_TRIG;
               end else begin
                  state_nxt = ST_CAPTURE;
               end
            end
         end
         ST_WAIT_TRIG: begin
            if (cmd_stop) begin
               state_nxt = ST_IDLE;
               ev_done   = 1'b1;
            end else if (trig_fall) begin
               trig_seen_nxt = 1'b1;
               ev_trig       = 1'b1;
               state_nxt     = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            if (mem_we) begin
               // The pointer decides the wrap; the fill count saturates at the limit.
               if (run_mode_r == MODE_EXT_STOP && {1'b0, wptr_r} + 1'b1 >= limit_r) begin
                  wptr_nxt    = '0;
                  wrapped_nxt = 1'b1;
                  count_nxt   = limit_r;
               end else begin
                  wptr_nxt  = wptr_r + 1'b1;
                  count_nxt = wrapped_r ? limit_r : count_r + 1'b1;
               end
               if (run_mode_r != MODE_EXT_STOP && count_r + 1'b1 >= limit_r) begin
                  full_nxt = 1'b1;
               end
            end
            if (run_mode_r == MODE_EXT_STOP && trig_fall && !trig_seen_r) begin
               trig_seen_nxt = 1'b1;
               ev_trig       = 1'b1;
               state_nxt     = ST_IDLE;
               ev_done       = 1'b1;
            end else if (cmd_stop || full_nxt) begin
               state_nxt = ST_IDLE;
               ev_done   = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_r     <= ST_IDLE;
         wptr_r      <= '0;
         count_r     <= '0;
         trig_seen_r <= 1'b0;
         full_r      <= 1'b0;
         wrapped_r   <= 1'b0;
         pause_r     <= 1'b0;
         line_r      <= LINE_J;
         run_mode_r  <= MODE_MANUAL;
         limit_r     <= '0;
      end else begin
         state_r     <= state_nxt;
         wptr_r      <= wptr_nxt;
         count_r     <= count_nxt;
         trig_seen_r <= trig_seen_nxt;
         full_r      <= full_nxt;
         wrapped_r   <= wrapped_nxt;
         pause_r     <= pause_nxt;
         line_r      <= line_nxt;
         run_mode_r  <= run_mode_nxt;
         limit_r     <= limit_nxt;
      end
   end

   // Register file.
   always_comb begin
      ctrl_nxt    = ctrl_r;
      rd_addr_nxt = rd_addr_r;
      irq_en_nxt  = irq_en_r;
      irq_st_nxt  = irq_st_r;
      rdata_nxt   = 32'h0000_0000;
      if (wr_in) begin
         // Mode and size written mid-capture take effect at the next record; low speed and idle skipping act at once.
         if (is_addr(addr_in, OFF_CTRL)) begin
            ctrl_nxt = wdata_in;
         end
         if (is_addr(addr_in, OFF_RD_ADDR)) begin
            rd_addr_nxt = wdata_in[AW-1:0];
         end
         if (is_addr(addr_in, OFF_IRQ_EN)) begin
            irq_en_nxt = wdata_in[IRQ_W-1:0];
         end
         if (is_addr(addr_in, OFF_IRQ_CLR)) begin
            irq_st_nxt = irq_st_r & ~wdata_in[IRQ_W-1:0];
         end
      end
      // Set wins over a clear in the same cycle.
      irq_st_nxt[IRQ_TRIG] = irq_st_nxt[IRQ_TRIG] | ev_trig;
      irq_st_nxt[IRQ_DONE] = irq_st_nxt[IRQ_DONE] | ev_done;
      if (rd_in) begin
         case (addr_in)
            OFF_CTRL:    rdata_nxt = ctrl_r;
            OFF_STATUS: begin
               rdata_nxt[ST_ARMED]     = state_r == ST_WAIT_TRIG;
               rdata_nxt[ST_CAPTURING] = state_r == ST_CAPTURE;
               rdata_nxt[ST_TRIGGERED] = trig_seen_r;
               rdata_nxt[ST_FULL]      = full_r;
               rdata_nxt[ST_WRAPPED]   = wrapped_r;
            end
            OFF_WPTR:    rdata_nxt = 32'(wptr_r);
            OFF_IRQ_ST:  rdata_nxt = 32'(irq_st_r);
            OFF_IRQ_EN:  rdata_nxt = 32'(irq_en_r);
            OFF_RD_ADDR: rdata_nxt = 32'(rd_addr_r);
            OFF_RD_DATA: rdata_nxt = 32'(mem_rdata);
            default:     rdata_nxt = 32'h0000_0000;
         endcase
      end
      irq_nxt = |(irq_st_nxt & irq_en_nxt);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_r    <= CTRL_RESET;
         rd_addr_r <= '0;
         irq_st_r  <= '0;
         irq_en_r  <= '0;
         rdata_r   <= 32'h0000_0000;
         irq_r     <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         rd_addr_r <= rd_addr_nxt;
         irq_st_r  <= irq_st_nxt;
         irq_en_r  <= irq_en_nxt;
         rdata_r   <= rdata_nxt;
         irq_r     <= irq_nxt;
      end
   end

   // The memory reads ahead from the next read address, so a data read may follow
   // an address write with no gap and still come out of the read data register.
   assign rdata_out = rdata_r;
   assign irq_out   = irq_r;

   record_start_a: assert property (@(posedge clock_in) disable iff (rst_in)
      state_r == ST_IDLE && !cmd_record |=> state_r == ST_IDLE)
      else $error("Capture began without a record command.");
   ext_start_arm_a: assert property (@(posedge clock_in) disable iff (rst_in)
      state_r == ST_IDLE && cmd_record && ctrl_r[1:0] == 2'b01 |=> state_r == ST_WAIT_TRIG)
      else $error("External start did not only arm.");
   manual_go_a: assert property (@(posedge clock_in) disable iff (rst_in)
      state_r == ST_IDLE && cmd_record && ctrl_r[1:0] == 2'b00 |=> state_r == ST_CAPTURE)
      else $error("Manual record did not start capture.");
   stop_cmd_a: assert property (@(posedge clock_in) disable iff (rst_in)
      state_r != ST_IDLE && cmd_stop |=> state_r == ST_IDLE)
      else $error("Stop command did not end recording.");
   full_stop_a: assert property (@(posedge clock_in) disable iff (rst_in)
      full_r |-> state_r == ST_IDLE && count_r == limit_r)
      else $error("Full flag without stop at limit.");
   ring_bound_a: assert property (@(posedge clock_in) disable iff (rst_in)
      count_r <= limit_r)
      else $error("Circular buffer overran its limit.");
   trig_start_a: assert property (@(posedge clock_in) disable iff (rst_in)
      state_r == ST_WAIT_TRIG && trig_fall && !cmd_stop |=> state_r == ST_CAPTURE && trig_seen_r)
      else $error("Trigger did not start capture.");
   idle_pause_a: assert property (@(posedge clock_in) disable iff (rst_in)
      pause_r && !ctrl_r[CTRL_NOIDLE] && tick |=> !pause_r)
      else $error("Pause held with idle recording on.");
   irq_level_a: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(irq_st_r[IRQ_TRIG]) && irq_en_r[IRQ_TRIG] |-> irq_r)
      else $error("Trigger interrupt not raised.");

   manual_run_c: cover property (@(posedge clock_in) state_r == ST_CAPTURE && run_mode_r == MODE_MANUAL && full_nxt);
   ext_start_c:  cover property (@(posedge clock_in) state_r == ST_WAIT_TRIG && trig_fall);
   ring_wrap_c:  cover property (@(posedge clock_in) $rose(wrapped_r));
   idle_skip_c:  cover property (@(posedge clock_in) $fell(pause_r) && ctrl_r[CTRL_NOIDLE]);

endmodule
`default_nettype wire

//--- tb/utcr_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: holds a line state on D+ and D- and pulls the trigger line low on request.
module utcr_bus_model (
   // Clock
   input  wire logic       clock_in,
   // Control from the bench
   input  wire logic [1:0] line_in,
   input  wire logic       fire_in,
   // Monitored line and trigger
   output logic            dp_out,
   output logic            dm_out,
   output logic            trig_n_out
);
   int unsigned hold_cnt = 0;
   assign dp_out = line_in[1];
   assign dm_out = line_in[0];
   // The trigger rests high on its pull-up; eight clocks low survive any synchroniser.
   always @(posedge clock_in) begin
      if (fire_in) begin
         hold_cnt <= 8;
      end else if (hold_cnt != 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   assign trig_n_out = (hold_cnt == 0);
endmodule
`default_nettype wire

//--- tb/usb_traffic_capture_recorder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_traffic_capture_recorder_tb;
   import utcr_pkg::*;
   // A small memory keeps every fill short; limits below follow from it.
   localparam int AW    = 6;
   localparam int DEPTH = 1 << AW;
   logic        clock_in = 1'b0;
   logic        rst_in   = 1'b1;
   logic [7:0]  addr     = 8'h00;
   logic [31:0] wdata    = 32'h0000_0000;
   logic        wr       = 1'b0;
   logic        rd       = 1'b0;
   logic        fire     = 1'b0;
   logic [1:0]  line     = LINE_J;
   logic [31:0] rdata;
   logic        dp;
   logic        dm;
   logic        trig_n;
   logic        irq;
   logic [31:0] st;
   logic [31:0] d;
   logic        hit;
   int          dt;
   int          error_cnt  = 0;
   int          num_checks = 0;
   int          cyc        = 0;

   utcr_recorder #(.AW(AW)) i_utcr_recorder (
      .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .dp_in(dp), .dm_in(dm),
      .trig_n_in(trig_n), .irq_out(irq));
   utcr_bus_model i_utcr_bus_model (
      .clock_in(clock_in), .line_in(line), .fire_in(fire),
      .dp_out(dp), .dm_out(dm), .trig_n_out(trig_n));

   initial begin
      forever #5 clock_in = ~clock_in;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // The longest scenario needs well under a tenth of this ceiling.
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic mem_rd(input logic [31:0] a, output logic [31:0] v);
      reg_wr(OFF_RD_ADDR, a);
      reg_rd(OFF_RD_DATA, v);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   task automatic pulse_trig();
      @(posedge clock_in);
      fire <= 1'b1;
      @(posedge clock_in);
      fire <= 1'b0;
      idle(20);
   endtask

   // Polls one status bit until set; reports the cycles spent and whether it came.
   task automatic poll(input int idx, input int max_rd, output int t, output logic got);
      int t0;
      t0  = cyc;
      got = 1'b0;
      for (int n = 0; n < max_rd && got !== 1'b1; n++) begin
         reg_rd(OFF_STATUS, st);
         got = st[idx];
      end
      t = cyc - t0;
   endtask

   function automatic logic [31:0] ctrl(input logic [1:0] m, input logic s, input logic l,
                                        input logic [3:0] t);
      return {24'h0000_00, t, l, s, m};
   endfunction

   task automatic t_reset();
      reg_rd(OFF_CTRL, d);
      check("ctrl_reset", d, CTRL_RESET);
      reg_rd(OFF_STATUS, d);
      check("status_reset", d, 32'h0000_0000);
      reg_rd(8'h40, d);
      check("unmapped", d, 32'h0000_0000);
      check("irq_reset", irq, 1'b0);
   endtask

   task automatic t_manual_full();
      reg_wr(OFF_IRQ_EN, 32'h0000_0003);
      reg_wr(OFF_CTRL, ctrl(MODE_MANUAL, 1'b0, 1'b0, 4'h5));
      idle(100);
      reg_rd(OFF_STATUS, st);
      check("no_capture", st[ST_CAPTURING], 1'b0);
      reg_wr(OFF_CMD, 32'h0000_0001);
      reg_rd(OFF_STATUS, st);
      check("capturing", st[ST_CAPTURING], 1'b1);
      poll(ST_FULL, 200, dt, hit);
      check("full", hit, 1'b1);
      check("fill_time", (dt >= DEPTH / 2 * FS_DIV - 16) && (dt <= DEPTH / 2 * FS_DIV + 16),
            1'b1);
      check("stopped", st[ST_CAPTURING], 1'b0);
      mem_rd(32'h0000_0000, d);
      check("idle_sample", d[1:0], LINE_J);
      check("irq_done", irq, 1'b1);
      reg_wr(OFF_IRQ_CLR, 32'h0000_0003);
      idle(1);
      check("irq_clear", irq, 1'b0);
   endtask

   task automatic t_manual_stop();
      reg_wr(OFF_CTRL, ctrl(MODE_MANUAL, 1'b0, 1'b0, 4'ha));
      reg_wr(OFF_CMD, 32'h0000_0001);
      pulse_trig();
      reg_rd(OFF_STATUS, st);
      check("trig_ignored", st[ST_TRIGGERED], 1'b0);
      check("still_on", st[ST_CAPTURING], 1'b1);
      reg_wr(OFF_CMD, 32'h0000_0002);
      reg_rd(OFF_STATUS, st);
      check("stop_cmd", st[ST_CAPTURING], 1'b0);
      check("not_full", st[ST_FULL], 1'b0);
   endtask

   task automatic t_ext_start();
      reg_wr(OFF_IRQ_CLR, 32'h0000_0003);
      reg_wr(OFF_CTRL, ctrl(MODE_EXT_START, 1'b0, 1'b0, 4'h1));
      reg_wr(OFF_CMD, 32'h0000_0001);
      idle(80);
      reg_rd(OFF_STATUS, st);
      check("armed", st[ST_ARMED], 1'b1);
      check("waiting", st[ST_CAPTURING], 1'b0);
      pulse_trig();
      reg_rd(OFF_IRQ_ST, d);
      check("trig_irq", d[IRQ_TRIG], 1'b1);
      poll(ST_FULL, 40, dt, hit);
      check("ext_full", hit, 1'b1);
      check("triggered", st[ST_TRIGGERED], 1'b1);
   endtask

   task automatic t_ext_stop();
      reg_wr(OFF_CTRL, ctrl(MODE_EXT_STOP, 1'b0, 1'b0, 4'ha));
      reg_wr(OFF_CMD, 32'h0000_0001);
      idle(DEPTH * FS_DIV + 100);
      reg_rd(OFF_STATUS, st);
      check("runs_on", st[ST_CAPTURING], 1'b1);
      check("wrapped", st[ST_WRAPPED], 1'b1);
      check("no_full", st[ST_FULL], 1'b0);
      pulse_trig();
      reg_rd(OFF_STATUS, st);
      check("trig_stop", st[ST_CAPTURING], 1'b0);
      check("trig_seen", st[ST_TRIGGERED], 1'b1);
      // About 77 ticks ran before the trigger, so the ring holds its pointer near 13.
      reg_rd(OFF_WPTR, d);
      check("ring_wptr", (d >= 10) && (d <= 16), 1'b1);
   endtask

   task automatic t_low_speed();
      @(posedge clock_in);
      line <= LINE_K;
      reg_wr(OFF_CTRL, ctrl(MODE_MANUAL, 1'b0, 1'b1, 4'h1));
      reg_wr(OFF_CMD, 32'h0000_0001);
      poll(ST_FULL, 260, dt, hit);
      check("ls_full", hit, 1'b1);
      check("ls_rate", (dt >= 6 * LS_DIV - 80) && (dt <= 6 * LS_DIV + 80), 1'b1);
      mem_rd(32'h0000_0000, d);
      check("ls_swap", d[1:0], {LINE_K[0], LINE_K[1]});
   endtask

   task automatic t_skip_idle();
      @(posedge clock_in);
      line <= LINE_J;
      reg_wr(OFF_CTRL, ctrl(MODE_MANUAL, 1'b1, 1'b0, 4'h1));
      reg_wr(OFF_CMD, 32'h0000_0001);
      idle(300);
      reg_rd(OFF_STATUS, st);
      check("idle_paused", st[ST_FULL], 1'b0);
      check("still_rec", st[ST_CAPTURING], 1'b1);
      @(posedge clock_in);
      line <= LINE_K;
      poll(ST_FULL, 40, dt, hit);
      check("sop_resume", hit, 1'b1);
   endtask

   initial begin
      idle(2);
      rst_in <= 1'b0;
      t_reset();
      t_manual_full();
      t_manual_stop();
      t_ext_start();
      t_ext_stop();
      t_low_speed();
      t_skip_idle();
      print_verdict();
   end
endmodule
`default_nettype wire
